/* verilog/strap_cfg_params.svh */
`ifndef STRAP_CFG_PARAMS_SVH
`define STRAP_CFG_PARAMS_SVH
`define CLK_FREQ_MHZ 40
`define STRAP_MIN_NS 9400
`define STRAP_MAX_NS 25600
`define STRAP_MIN_CYC ((`STRAP_MIN_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define STRAP_MAX_CYC ((`STRAP_MAX_NS * `CLK_FREQ_MHZ) / 1000)
`define STRAP_HOLD_CYC `STRAP_MIN_CYC
`define PWR_REG_INDEX 7'h1e
`define PWR_SW_RESET 8'h07
`define PWR_HW_RESET 8'h00
`define PLL_OFF_BIT 0
`define RECEIVER_OFF_BIT 1
`define TRANSMITTER_OFF_BIT 2
`define OSCILLATOR_OFF_BIT 3
`define AUDIO_PORT_OFF_BIT 4
`define OUTPUTS_HIGH_Z_BIT 5
`define FRAME_BITS 16
`define HOST_DIV 4
`define HOST_CTRL_ADDR 4'h0
`define HOST_DATA_ADDR 4'h4
`define HOST_STAT_ADDR 4'h8
`endif

/* verilog/strap_cfg_pkg.sv */
package strap_cfg_pkg;
  typedef enum logic [2:0] {
    ST_STRAP = 3'b001,
    ST_RUN = 3'b010,
    ST_IDLE_SPARE = 3'b100
  } dev_state_t;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LOW = 4'b0010,
    H_HIGH = 4'b0100,
    H_LATCH = 4'b1000
  } host_state_t;
endpackage

/* verilog/serial_ctrl_if.sv */
`timescale 1ns/10ps
interface serial_ctrl_if;
  logic sclk;
  logic sdin;
  logic chip_select_n;
  logic sdout;
  logic gp_out;
  logic sdin_oe;
  logic sclk_oe;
  logic cs_oe;
  logic gp_out_oe;
  logic sdout_oe;
  logic dev_sdout;
  logic dev_gp_out;
  logic dev_sdout_oe;
  logic dev_gp_out_oe;
  modport device_end (
    input sclk,
    input sdin,
    input chip_select_n,
    input sdout,
    input gp_out,
    output dev_sdout,
    output dev_sdout_oe,
    output dev_gp_out,
    output dev_gp_out_oe
  );
  modport host_end (
    output sclk,
    output sdin,
    output chip_select_n,
    output sdin_oe,
    output sclk_oe,
    output cs_oe,
    output sdout_oe,
    output gp_out_oe,
    output gp_out,
    output sdout
  );
endinterface

/* verilog/strap_config_serial_ctrl_front.sv */
// Operation
// - Straps choose configuration at reset
// - Pins stay inputs 9.4 to 25.6 us
// - Afterwards pins take their chosen function
// - Data strap 0 pin mode, 1 host
// - Select strap 0 two-wire, 1 three-wire
// - Host mode starts everything powered down; code powers down only PLL, rx, tx (8'h07)
// - Pin mode powers everything up
// - Bits 0..2 disable PLL, rx, tx
// - Bits 3,4 power down oscillator, audio port
// - Bit 5 tri-states all outputs
// - Pin mode: two straps select audio format
// - Three-wire writes, fourth wire for reads; reads not supported here
// - Data sampled on serial clock rising edge
// - Chip select low throughout or short pulse
// - Direction bit 0 write, 1 read
// - Seven address bits, eight data bits
// - Write committed on chip select rising edge
// - Two-wire: chip select strap picks address
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/10ps
`include "strap_cfg_params.svh"
module strap_config_serial_ctrl_front #(
  parameter int STRAP_CYC = `STRAP_HOLD_CYC
) (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Serial control pins
  serial_ctrl_if.device_end pins,
  // Strap pins sampled alongside the control pins
  input wire logic audio_port_role_strap_i,
  input wire logic audio_port_format0_strap_i,
  input wire logic transmit_source_strap_i,
  // Configuration outputs
  output logic cfg_done_o,
  output logic host_controlled_mode_o,
  output logic three_wire_mode_o,
  output logic bus_addr_high_o,
  output logic [1:0] audio_port_format_o,
  output logic audio_port_role_o,
  output logic transmit_source_o,
  // Power control and register write outputs
  output logic [7:0] block_power_down_control_o,
  output logic pll_off_o,
  output logic receiver_off_o,
  output logic transmitter_off_o,
  output logic oscillator_off_o,
  output logic audio_port_off_o,
  output logic outputs_high_z_o,
  output logic write_strobe_o,
  output logic [6:0] reg_index_o,
  output logic [7:0] write_data_o
);
  // Two-stage synchronisers for all pins
  logic [8:0] pin_raw;
  logic [8:0] sync1_r;
  logic [8:0] sync2_r;
  logic [8:0] sync1_nxt;
  logic [8:0] sync2_nxt;
  logic sclk_s;
  logic sdin_s;
  logic cs_s;
  logic sdout_s;
  logic gp_out_s;
  assign pin_raw = {transmit_source_strap_i, audio_port_format0_strap_i,
    audio_port_role_strap_i, pins.gp_out, pins.sdout, pins.chip_select_n,
    pins.sdin, pins.sclk, 1'b0};
  always_comb
  begin
    sync1_nxt = pin_raw;
    sync2_nxt = sync1_r;
  end
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      sync1_r <= 9'h000;
      sync2_r <= 9'h000;
    end
    else if (clk_en_i)
    begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end
  assign sclk_s = sync2_r[1];
  assign sdin_s = sync2_r[2];
  assign cs_s = sync2_r[3];
  assign sdout_s = sync2_r[4];
  assign gp_out_s = sync2_r[5];

  // Strap phase and serial write engine
  strap_cfg_pkg::dev_state_t state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic hcm_r, hcm_nxt;
  logic tw_r, tw_nxt;
  logic addr_hi_r, addr_hi_nxt;
  logic [1:0] fmt_r, fmt_nxt;
  logic role_r, role_nxt;
  logic tx_source_r, tx_source_nxt;
  logic [7:0] pwr_r, pwr_nxt;
  logic sclk_d_r, sclk_d_nxt;
  logic cs_d_r, cs_d_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic [4:0] nbits_r, nbits_nxt;
  logic wstb_r, wstb_nxt;
  logic [6:0] widx_r, widx_nxt;
  logic [7:0] wdat_r, wdat_nxt;
  logic oe_r, oe_nxt;
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    hcm_nxt = hcm_r;
    tw_nxt = tw_r;
    addr_hi_nxt = addr_hi_r;
    fmt_nxt = fmt_r;
    role_nxt = role_r;
    tx_source_nxt = tx_source_r;
    pwr_nxt = pwr_r;
    sclk_d_nxt = sclk_s;
    cs_d_nxt = cs_s;
    shift_nxt = shift_r;
    nbits_nxt = nbits_r;
    wstb_nxt = 1'b0;
    widx_nxt = widx_r;
    wdat_nxt = wdat_r;
    case (state_r)
      strap_cfg_pkg::ST_STRAP:
      begin
        // Pins stay inputs; sample straps at the end of the window
        if (cnt_r < 16'(STRAP_CYC))
          cnt_nxt = cnt_r + 16'h0001;
        else
        begin
          hcm_nxt = sdin_s;
          // Interface select only means something in host mode
          tw_nxt = sdin_s && gp_out_s;
          addr_hi_nxt = cs_s;
          fmt_nxt = {gp_out_s, sdout_s};
          role_nxt = sclk_s;
          tx_source_nxt = cs_s;
          pwr_nxt = sdin_s ? `PWR_SW_RESET : `PWR_HW_RESET;
          state_nxt = strap_cfg_pkg::ST_RUN;
        end
      end
      strap_cfg_pkg::ST_RUN:
      begin
        if (hcm_r && tw_r)
        begin
          if (sclk_s && !sclk_d_r && nbits_r != 5'h1f)
          begin
            shift_nxt = {shift_r[14:0], sdin_s};
            nbits_nxt = nbits_r + 5'h01;
          end
          if (cs_s && !cs_d_r)
          begin
            if (nbits_r >= 5'(`FRAME_BITS) && !shift_r[15])
            begin
              wstb_nxt = 1'b1;
              widx_nxt = shift_r[14:8];
              wdat_nxt = shift_r[7:0];
              if (shift_r[14:8] == `PWR_REG_INDEX)
                pwr_nxt = shift_r[7:0];
            end
            nbits_nxt = 5'h00;
          end
        end
      end
      default:
        state_nxt = strap_cfg_pkg::ST_STRAP;
    endcase
    // Registered so the pin enable lines up with the run state
    oe_nxt = (state_nxt == strap_cfg_pkg::ST_RUN) && !(hcm_nxt && tw_nxt)
      && !pwr_nxt[`OUTPUTS_HIGH_Z_BIT];
  end
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= strap_cfg_pkg::ST_STRAP;
      cnt_r <= 16'h0000;
      hcm_r <= 1'b0;
      tw_r <= 1'b0;
      addr_hi_r <= 1'b0;
      fmt_r <= 2'h0;
      role_r <= 1'b0;
      tx_source_r <= 1'b0;
      pwr_r <= 8'h00;
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      shift_r <= 16'h0000;
      nbits_r <= 5'h00;
      wstb_r <= 1'b0;
      widx_r <= 7'h00;
      wdat_r <= 8'h00;
      oe_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      hcm_r <= hcm_nxt;
      tw_r <= tw_nxt;
      addr_hi_r <= addr_hi_nxt;
      fmt_r <= fmt_nxt;
      role_r <= role_nxt;
      tx_source_r <= tx_source_nxt;
      pwr_r <= pwr_nxt;
      sclk_d_r <= sclk_d_nxt;
      cs_d_r <= cs_d_nxt;
      shift_r <= shift_nxt;
      nbits_r <= nbits_nxt;
      wstb_r <= wstb_nxt;
      widx_r <= widx_nxt;
      wdat_r <= wdat_nxt;
      oe_r <= oe_nxt;
    end
  end
  // One-hot: bit 1 is the run state
  assign cfg_done_o = state_r[1];
  assign host_controlled_mode_o = hcm_r;
  assign three_wire_mode_o = tw_r;
  assign bus_addr_high_o = addr_hi_r;
  assign audio_port_format_o = fmt_r;
  assign audio_port_role_o = role_r;
  assign transmit_source_o = tx_source_r;
  assign block_power_down_control_o = pwr_r;
  assign pll_off_o = pwr_r[`PLL_OFF_BIT];
  assign receiver_off_o = pwr_r[`RECEIVER_OFF_BIT];
  assign transmitter_off_o = pwr_r[`TRANSMITTER_OFF_BIT];
  assign oscillator_off_o = pwr_r[`OSCILLATOR_OFF_BIT];
  assign audio_port_off_o = pwr_r[`AUDIO_PORT_OFF_BIT];
  assign outputs_high_z_o = pwr_r[`OUTPUTS_HIGH_Z_BIT];
  assign write_strobe_o = wstb_r;
  assign reg_index_o = widx_r;
  assign write_data_o = wdat_r;
  // Pins driven only after configuration; read-back is not supported, so sdout stays low
  assign pins.dev_sdout = 1'b0;
  assign pins.dev_sdout_oe = 1'b0;
  assign pins.dev_gp_out = 1'b0;
  assign pins.dev_gp_out_oe = oe_r;
endmodule

/* verilog/serial_ctrl_host.sv */
`timescale 1ns/10ps
`include "strap_cfg_params.svh"
module serial_ctrl_host #(
  parameter int DIV = `HOST_DIV
) (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Serial link
  serial_ctrl_if.host_end pins
);
  strap_cfg_pkg::host_state_t st_r, st_nxt;
  logic [2:0] strap_r, strap_nxt;
  logic [15:0] frame_r, frame_nxt;
  logic [4:0] bit_r, bit_nxt;
  logic [7:0] div_r, div_nxt;
  logic sclk_r, sclk_nxt;
  logic sdin_r, sdin_nxt;
  logic cs_r, cs_nxt;
  logic drv_r, drv_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic ack_r, ack_nxt;
  logic req;
  assign req = (avs_read_i || avs_write_i) && !ack_r;
  always_comb
  begin
    st_nxt = st_r;
    strap_nxt = strap_r;
    frame_nxt = frame_r;
    bit_nxt = bit_r;
    div_nxt = div_r;
    sclk_nxt = sclk_r;
    sdin_nxt = sdin_r;
    cs_nxt = cs_r;
    drv_nxt = drv_r;
    rd_nxt = rd_r;
    ack_nxt = 1'b0;
    if (req)
    begin
      ack_nxt = 1'b1;
      rd_nxt = 32'h00000000;
      if (avs_write_i && avs_address_i == `HOST_CTRL_ADDR)
      begin
        strap_nxt = avs_writedata_i[2:0];
        drv_nxt = avs_writedata_i[3];
      end
      else if (avs_write_i && avs_address_i == `HOST_DATA_ADDR && st_r == strap_cfg_pkg::H_IDLE)
      begin
        frame_nxt = {1'b0, avs_writedata_i[14:8], avs_writedata_i[7:0]};
        bit_nxt = 5'h00;
        div_nxt = 8'h00;
        cs_nxt = 1'b0;
        st_nxt = strap_cfg_pkg::H_LOW;
      end
      else if (avs_read_i && avs_address_i == `HOST_CTRL_ADDR)
        rd_nxt = {28'h0000000, drv_r, strap_r};
      else if (avs_read_i && avs_address_i == `HOST_STAT_ADDR)
        rd_nxt = {31'h0, st_r != strap_cfg_pkg::H_IDLE};
    end
    case (st_r)
      strap_cfg_pkg::H_IDLE:
        sclk_nxt = 1'b0;
      strap_cfg_pkg::H_LOW:
      begin
        sclk_nxt = 1'b0;
        sdin_nxt = frame_r[15];
        div_nxt = div_r + 8'h01;
        if (div_r == 8'(DIV - 1))
        begin
          div_nxt = 8'h00;
          st_nxt = strap_cfg_pkg::H_HIGH;
        end
      end
      strap_cfg_pkg::H_HIGH:
      begin
        sclk_nxt = 1'b1;
        div_nxt = div_r + 8'h01;
        if (div_r == 8'(DIV - 1))
        begin
          div_nxt = 8'h00;
          frame_nxt = {frame_r[14:0], 1'b0};
          bit_nxt = bit_r + 5'h01;
          st_nxt = (bit_r == 5'(`FRAME_BITS - 1)) ? strap_cfg_pkg::H_LATCH
            : strap_cfg_pkg::H_LOW;
        end
      end
      strap_cfg_pkg::H_LATCH:
      begin
        sclk_nxt = 1'b0;
        div_nxt = div_r + 8'h01;
        if (div_r == 8'(DIV - 1))
        begin
          cs_nxt = 1'b1;
          st_nxt = strap_cfg_pkg::H_IDLE;
        end
      end
      default:
        st_nxt = strap_cfg_pkg::H_IDLE;
    endcase
  end
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= strap_cfg_pkg::H_IDLE;
      strap_r <= 3'h0;
      frame_r <= 16'h0000;
      bit_r <= 5'h00;
      div_r <= 8'h00;
      sclk_r <= 1'b0;
      sdin_r <= 1'b0;
      cs_r <= 1'b1;
      drv_r <= 1'b0;
      rd_r <= 32'h00000000;
      ack_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      st_r <= st_nxt;
      strap_r <= strap_nxt;
      frame_r <= frame_nxt;
      bit_r <= bit_nxt;
      div_r <= div_nxt;
      sclk_r <= sclk_nxt;
      sdin_r <= sdin_nxt;
      cs_r <= cs_nxt;
      drv_r <= drv_nxt;
      rd_r <= rd_nxt;
      ack_r <= ack_nxt;
    end
  end
  assign avs_readdata_o = rd_r;
  assign avs_waitrequest_o = !ack_r;
  // Strap levels on sdin while idle, on cs while idle with drv set, gpo enabled by drv; else serial link levels
  assign pins.sdin = (st_r == strap_cfg_pkg::H_IDLE) ? strap_r[0] : sdin_r;
  assign pins.gp_out = strap_r[1];
  assign pins.sdout = 1'b0;
  assign pins.sclk = sclk_r;
  assign pins.chip_select_n = (st_r == strap_cfg_pkg::H_IDLE && drv_r) ? strap_r[2] : cs_r;
  assign pins.sdin_oe = 1'b1;
  assign pins.sclk_oe = 1'b1;
  assign pins.cs_oe = 1'b1;
  assign pins.gp_out_oe = drv_r;
  assign pins.sdout_oe = 1'b0;
endmodule

/* tb/scf_monitor.sv */
`timescale 1ns/10ps
module scf_monitor #(
  parameter int STRAP_CYC = 8
) (
  // Clock and reset
  input logic core_clk_i,
  input logic rst_n_i,
  // Link pins and device status
  input logic sclk,
  input logic sdin,
  input logic chip_select_n,
  input logic dev_gp_out_oe,
  input logic dev_sdout_oe,
  input logic cfg_done_o,
  input logic host_controlled_mode_o,
  input logic three_wire_mode_o,
  input logic write_strobe_o,
  input logic [7:0] block_power_down_control_o
);
  logic sclk_r, sclk_nxt;
  logic [10:0] win_r, win_nxt;
  logic [4:0] rise_r, rise_nxt;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Cycles since reset release, serial clock rises while selected
  always_comb
  begin
    sclk_nxt = sclk;
    win_nxt = cfg_done_o ? win_r : win_r + 11'h001;
    rise_nxt = chip_select_n ? 5'h00 : rise_r + {4'h0, sclk & ~sclk_r};
    if (!rst_n_i)
    begin
      win_nxt = 11'h000;
      rise_nxt = 5'h00;
    end
  end
  always_ff @(posedge core_clk_i)
  begin
    sclk_r <= sclk_nxt;
    win_r <= win_nxt;
    rise_r <= rise_nxt;
  end
  sequence s_cs_up;
    !chip_select_n ##1 chip_select_n;
  endsequence
  sequence s_bit_in;
    $rose(sclk) ##0 !chip_select_n;
  endsequence
  property p_pins_in;
    !cfg_done_o |-> !dev_gp_out_oe && !dev_sdout_oe;
  endproperty
  a_pins_in: assert property (p_pins_in) else $error("pin driven in window");
  property p_window;
    $rose(cfg_done_o) |-> win_r >= 11'(STRAP_CYC + 1) && win_r <= 11'(STRAP_CYC + 5);
  endproperty
  a_window: assert property (p_window) else $error("strap window length");
  property p_held;
    cfg_done_o [*3] |=> $stable(host_controlled_mode_o) && $stable(three_wire_mode_o);
  endproperty
  a_held: assert property (p_held) else $error("mode changed");
  property p_pwr_dflt;
    $rose(cfg_done_o) |-> ##[0:2]
      block_power_down_control_o == (host_controlled_mode_o ? 8'h07 : 8'h00);
  endproperty
  a_pwr_dflt: assert property (p_pwr_dflt) else $error("power default");
  property p_commit;
    s_cs_up ##0 (cfg_done_o && three_wire_mode_o) |-> ##[1:6] write_strobe_o;
  endproperty
  a_commit: assert property (p_commit) else $error("no commit");
  property p_frame_len;
    s_cs_up ##0 (cfg_done_o && three_wire_mode_o) |-> rise_r == 5'h10;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length");
  property p_sdin_stable;
    s_bit_in |-> $stable(sdin);
  endproperty
  a_sdin_stable: assert property (p_sdin_stable) else $error("data moved");
  property p_dir_write;
    s_bit_in ##0 (rise_r == 5'h00) |-> !sdin;
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction bit");
endmodule

/* tb/test_strap_config_serial_ctrl_front.sv */
`timescale 1ns/10ps
`define CHK(nm, e, s) \
  begin \
    n_checks++; \
    if ((s) !== (e)) \
    begin \
      failures++; \
      $display("unexpected %s exp %h got %h", nm, e, s); \
    end \
  end
module test_strap_config_serial_ctrl_front;
  localparam int SC = 8;
  localparam logic [7:0] PV [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h3f, 8'h00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic dev_rst_n = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rdq;
  logic wait_rq, done, host_m, three_w, addr_hi, tx_src, stb, role;
  logic [1:0] fmt;
  logic [5:0] offb;
  logic [6:0] idx;
  logic [7:0] pwr, wd;
  int failures = 0;
  int n_checks = 0;
  serial_ctrl_if bus();
  always #12.5 clk = ~clk;
  strap_config_serial_ctrl_front #(
    .STRAP_CYC(SC)
  ) u_strap_config_serial_ctrl_front (
    .core_clk_i(clk),
    .rst_n_i(dev_rst_n),
    .clk_en_i(1'b1),
    .pins(bus),
    .audio_port_role_strap_i(1'b0),
    .audio_port_format0_strap_i(1'b0),
    .transmit_source_strap_i(1'b0),
    .cfg_done_o(done),
    .host_controlled_mode_o(host_m),
    .three_wire_mode_o(three_w),
    .bus_addr_high_o(addr_hi),
    .audio_port_format_o(fmt),
    .audio_port_role_o(role),
    .transmit_source_o(tx_src),
    .block_power_down_control_o(pwr),
    .pll_off_o(offb[0]),
    .receiver_off_o(offb[1]),
    .transmitter_off_o(offb[2]),
    .oscillator_off_o(offb[3]),
    .audio_port_off_o(offb[4]),
    .outputs_high_z_o(offb[5]),
    .write_strobe_o(stb),
    .reg_index_o(idx),
    .write_data_o(wd)
  );
  serial_ctrl_host u_serial_ctrl_host (
    .core_clk_i(clk),
    .rst_n_i(rst_n),
    .clk_en_i(1'b1),
    .avs_address_i(adr),
    .avs_read_i(rd),
    .avs_write_i(wr),
    .avs_writedata_i(wdat),
    .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_rq),
    .pins(bus)
  );
  scf_monitor #(
    .STRAP_CYC(SC)
  ) u_scf_monitor (
    .core_clk_i(clk),
    .rst_n_i(dev_rst_n),
    .sclk(bus.sclk),
    .sdin(bus.sdin),
    .chip_select_n(bus.chip_select_n),
    .dev_gp_out_oe(bus.dev_gp_out_oe),
    .dev_sdout_oe(bus.dev_sdout_oe),
    .cfg_done_o(done),
    .host_controlled_mode_o(host_m),
    .three_wire_mode_o(three_w),
    .write_strobe_o(stb),
    .block_power_down_control_o(pwr)
  );
  task automatic wrap_up();
    if (failures == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= ~w;
    do
      @(posedge clk);
    while (wait_rq !== 1'b0);
    rdq = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic frame(input logic [6:0] i, input logic [7:0] v);
    av(1'b1, 4'h4, {17'h0, i, v});
    do
      @(posedge clk);
    while (stb !== 1'b1);
    `CHK("index", i, idx);
    `CHK("data", v, wd);
    do
      av(1'b0, 4'h8, 32'h0);
    while (rdq[0] !== 1'b0);
  endtask
  // Straps {cs, gpo0, sdin} set by the host during a device reset
  task automatic strap(input logic [2:0] s);
    int n;
    logic oe;
    n = 0;
    oe = 1'b0;
    dev_rst_n <= 1'b0;
    av(1'b1, 4'h0, {29'h1, s});
    repeat (4) @(posedge clk);
    dev_rst_n <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (done !== 1'b1)
        oe = oe | bus.dev_gp_out_oe | bus.dev_sdout_oe;
    end
    while (done !== 1'b1);
    `CHK("window", 1'b1, n >= SC + 1 && n <= SC + 5);
    `CHK("pins as inputs", 1'b0, oe);
    repeat (3) @(posedge clk);
    `CHK("host mode", s[0], host_m);
    `CHK("three wire", s[0] & s[1], three_w);
    `CHK("power", s[0] ? 8'h07 : 8'h00, pwr);
    if (s[0] & ~s[1])
      `CHK("bus address", s[2], addr_hi);
    if (~s[0])
    begin
      `CHK("format", {s[1], 1'b0}, fmt);
      `CHK("tx source", s[2], tx_src);
      `CHK("role", 1'b0, role);
      `CHK("output drive", 1'b1, bus.dev_gp_out_oe);
      av(1'b1, 4'h0, {29'h1, ~s});
      repeat (4) @(posedge clk);
      `CHK("held mode", 1'b0, host_m);
      `CHK("held tx source", s[2], tx_src);
    end
  endtask
  task automatic writes();
    foreach (PV[k])
    begin
      frame(7'h1e, PV[k]);
      `CHK("power reg", PV[k], pwr);
      `CHK("power bits", PV[k][5:0], offb);
    end
    frame(7'h1d, 8'hff);
    `CHK("untouched", 8'h00, pwr);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int s = 0; s < 8; s++)
      strap(3'(s));
    writes();
    wrap_up();
  end
  initial
  begin
    repeat (8000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule
